// ===== src/adcsp_serial_port.sv
// serial port of a sigma-delta converter: framed link and its registers
`timescale 1ns/10ps
`default_nettype none
module adcsp_serial_port
  import adcsp_pkg::*;
(
  // master clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // clock source select: high self-clocking, low external
  input wire logic clockMode,
  // serial clock pin, also the link domain clock
  input wire logic serialClockIn,
  output logic serialClockOut,
  output logic serialClockOe,
  // serial data pin
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  // frame strobes and register select from the host, result ready flag back to it
  input wire logic receive_frame_strobe_n,
  input wire logic transmit_frame_strobe_n,
  input wire logic register_select,
  output logic result_ready_n,
  // converter core side
  input wire adcsp_pkg::adcsp_word_t resultData,
  input wire logic resultLoad,
  input wire logic calReadSelect,
  output adcsp_pkg::adcsp_word_t controlWord,
  output adcsp_pkg::adcsp_word_t calWord,
  output logic controlWrite,
  output logic calWrite,
  output logic resultReadDone,
  output logic frameBusy
);
  import adcsp_pkg::*;

  // mclk domain
  logic [SYNC_W-1:0] pinSync;
  logic rfsS;
  logic tfsS;
  logic selS;
  logic modeS;
  logic frameActive;
  logic frameActiveD;
  logic frameEpoch;
  logic rdSeen;
  logic wrSeen;
  logic rdEvent;
  logic wrEvent;
  logic readIsData;
  logic genDone;
  adcsp_word_t resultReg;
  adcsp_word_t readWord;

  // link domain
  logic epochSeen;
  logic [CNT_W-1:0] linkBitCnt;
  logic [CNT_W-1:0] curCnt;
  logic rdBase;
  logic wrBase;
  logic rdDoneTgl;
  logic wrDoneTgl;
  logic linkSel;
  logic lastBit;
  logic linkFrame;
  adcsp_word_t rxShift;
  adcsp_word_t rxWord;

  adcsp_sync #(
    .WIDTH(SYNC_W),
    .RESET_VALUE(SYNC_RESET)
  ) u_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .asyncIn({wrDoneTgl, rdDoneTgl, clockMode, register_select,
              transmit_frame_strobe_n, receive_frame_strobe_n}),
    .syncOut(pinSync)
  );

  assign rfsS = pinSync[SY_RFS];
  assign tfsS = pinSync[SY_TFS];
  assign selS = pinSync[SY_SEL];
  assign modeS = pinSync[SY_MODE];
  assign frameActive = !rfsS || !tfsS;
  assign rdEvent = adcsp_edge(pinSync[SY_RDT], rdSeen);
  assign wrEvent = adcsp_edge(pinSync[SY_WRT], wrSeen);

  adcsp_sclk_gen u_sclk_gen (
    .mclk(mclk),
    .rst_n(rst_n),
    .selfClock(modeS),
    .frameActive(frameActive),
    .sclkOut(serialClockOut),
    .sclkOe(serialClockOe),
    .wordDone(genDone)
  );

  // ---------------- link domain, clocked by the pin ----------------

  // a changed epoch means this edge opens a new frame
  always_comb begin
    if (epochSeen == frameEpoch) begin
      curCnt = linkBitCnt;
      rdBase = rdDoneTgl;
      wrBase = wrDoneTgl;
    end else begin
      curCnt = '0;
      rdBase = rdSeen;
      wrBase = wrSeen;
    end
  end

  assign linkFrame = !receive_frame_strobe_n || !transmit_frame_strobe_n;
  assign lastBit = (curCnt == CNT_W'(WORD_BITS - 1));

  always_ff @(posedge serialClockIn) begin
    epochSeen <= frameEpoch;
  end

  // count survives any pause of the clock inside a frame
  always_ff @(posedge serialClockIn) begin
    if (linkFrame && lastBit) begin
      linkBitCnt <= '0;
    end else if (linkFrame) begin
      linkBitCnt <= curCnt + CNT_W'(1);
    end else begin
      // an edge outside a frame, such as the release of a cut self-clocked frame,
      // must not leave a stale position for the next frame
      linkBitCnt <= '0;
    end
  end

  always_ff @(posedge serialClockIn) begin
    if (linkFrame && curCnt == '0) begin
      linkSel <= register_select;
    end
  end

  always_ff @(posedge serialClockIn) begin
    if (!transmit_frame_strobe_n) begin
      rxShift <= {rxShift[WORD_BITS-2:0], serialDataIn};
    end
  end

  always_ff @(posedge serialClockIn) begin
    if (!transmit_frame_strobe_n && lastBit) begin
      rxWord <= {rxShift[WORD_BITS-2:0], serialDataIn};
    end
  end

  always_ff @(posedge serialClockIn) begin
    if (!transmit_frame_strobe_n && lastBit) begin
      wrDoneTgl <= ~wrBase;
    end else begin
      wrDoneTgl <= wrBase;
    end
  end

  always_ff @(posedge serialClockIn) begin
    if (!receive_frame_strobe_n && lastBit) begin
      rdDoneTgl <= ~rdBase;
    end else begin
      rdDoneTgl <= rdBase;
    end
  end

  // data changes on falling edges, the host samples on rising edges
  always_ff @(negedge serialClockIn) begin
    serialDataOut <= readWord[adcsp_bit_index(curCnt)];
  end

  // ---------------- mclk domain ----------------

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdSeen <= 1'b0;
      wrSeen <= 1'b0;
      frameActiveD <= 1'b0;
    end else begin
      // the link toggles are unset until the link first clocks; follow real changes only
      if (rdEvent) begin
        rdSeen <= pinSync[SY_RDT];
      end
      if (wrEvent) begin
        wrSeen <= pinSync[SY_WRT];
      end
      frameActiveD <= frameActive;
    end
  end

  // epoch flips only between frames, so the link sees it stable
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      frameEpoch <= 1'b0;
    end else if (frameActiveD && !frameActive) begin
      frameEpoch <= ~frameEpoch;
    end
  end

  // source word frozen while a frame runs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      readWord <= CONTROL_RESET;
      readIsData <= 1'b0;
    end else if (!frameActive) begin
      if (!selS) begin
        readWord <= controlWord;
        readIsData <= 1'b0;
      end else if (calReadSelect) begin
        readWord <= calWord;
        readIsData <= 1'b0;
      end else begin
        readWord <= resultReg;
        readIsData <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      resultReg <= RESULT_RESET;
    end else if (resultLoad) begin
      resultReg <= resultData;
    end
  end

  // a new result wins over the end of a read in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      result_ready_n <= 1'b1;
    end else if (resultLoad) begin
      result_ready_n <= 1'b0;
    end else if (rdEvent && linkSel && readIsData) begin
      result_ready_n <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      resultReadDone <= 1'b0;
    end else begin
      resultReadDone <= 1'b0;
      if (rdEvent && linkSel && readIsData) begin
        resultReadDone <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      controlWord <= CONTROL_RESET;
      controlWrite <= 1'b0;
    end else begin
      controlWrite <= 1'b0;
      if (wrEvent && !linkSel) begin
        controlWrite <= 1'b1;
        controlWord <= rxWord;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      calWord <= CAL_RESET;
      calWrite <= 1'b0;
    end else begin
      calWrite <= 1'b0;
      if (wrEvent && linkSel) begin
        calWrite <= 1'b1;
        calWord <= rxWord;
      end
    end
  end

  // data pin driven during a read frame, until the word has gone out in self-clocking mode and until the strobe rises otherwise
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      serialDataOe <= 1'b0;
      frameBusy <= 1'b0;
    end else begin
      serialDataOe <= !rfsS && !(modeS && genDone);
      frameBusy <= frameActive;
    end
  end
endmodule // adcsp_serial_port
`default_nettype wire

// ===== shared/adcsp_pkg.sv
// constants, types and helpers shared by the serial port design
package adcsp_pkg;

  // word length of every register reached over the link
  localparam int WORD_BITS = 24;
  localparam int CNT_W = 5;

  // self-clock shape in master clock cycles: short high, long low
  localparam int SCK_HIGH_CYCLES = 1;
  localparam int SCK_LOW_CYCLES = 3;
  localparam int PHASE_W = 2;

  // reset values
  localparam logic [WORD_BITS-1:0] CONTROL_RESET = 24'h000000;
  localparam logic [WORD_BITS-1:0] CAL_RESET = 24'h000000;
  localparam logic [WORD_BITS-1:0] RESULT_RESET = 24'h000000;

  // synchroniser bit layout and idle levels
  localparam int SYNC_W = 6;
  localparam int SY_RFS = 0;
  localparam int SY_TFS = 1;
  localparam int SY_SEL = 2;
  localparam int SY_MODE = 3;
  localparam int SY_RDT = 4;
  localparam int SY_WRT = 5;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h03;

  typedef logic [WORD_BITS-1:0] adcsp_word_t;

  typedef enum logic [3:0] {
    SG_IDLE = 4'b0001,
    SG_LOW  = 4'b0010,
    SG_HIGH = 4'b0100,
    SG_DONE = 4'b1000
  } adcsp_sg_state_t;

  // a toggle crossing marks an event when its two samples differ
  function automatic logic adcsp_edge(input logic now, input logic seen);
    return now ^ seen;
  endfunction

  // bit of the word that goes out at a given bit position, msb first
  function automatic logic [CNT_W-1:0] adcsp_bit_index(input logic [CNT_W-1:0] cnt);
    return CNT_W'(WORD_BITS - 1) - cnt;
  endfunction

endpackage

// ===== src/adcsp_sync.sv
// two-flop level synchroniser, one per bit
`timescale 1ns/10ps
`default_nettype none
module adcsp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous levels in, synchronous levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RESET_VALUE;
      syncOut <= RESET_VALUE;
    end else begin
      meta <= asyncIn;
      syncOut <= meta;
    end
  end
endmodule // adcsp_sync
`default_nettype wire

// ===== src/adcsp_sclk_gen.sv
// serial clock generator for self-clocking mode
`timescale 1ns/10ps
`default_nettype none
module adcsp_sclk_gen
  import adcsp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control, synchronised to mclk
  input wire logic selfClock,
  input wire logic frameActive,
  // serial clock pin drive and word end flag
  output logic sclkOut,
  output logic sclkOe,
  output logic wordDone
);
  adcsp_sg_state_t state;
  adcsp_sg_state_t next_state;
  logic [PHASE_W-1:0] phase;
  logic [CNT_W-1:0] pulses;
  logic run;

  assign run = selfClock && frameActive;

  always_comb begin
    next_state = state;
    case (state)
      SG_IDLE: begin
        if (run) begin
          next_state = SG_LOW;
        end
      end
      SG_LOW: begin
        if (!run) begin
          next_state = SG_IDLE;
        end else if (phase == PHASE_W'(SCK_LOW_CYCLES - 1)) begin
          next_state = SG_HIGH;
        end
      end
      SG_HIGH: begin
        if (!run) begin
          next_state = SG_IDLE;
        end else if (phase == PHASE_W'(SCK_HIGH_CYCLES - 1)) begin
          if (pulses == CNT_W'(WORD_BITS - 1)) begin
            next_state = SG_DONE;
          end else begin
            next_state = SG_LOW;
          end
        end
      end
      SG_DONE: begin
        if (!frameActive) begin
          next_state = SG_IDLE;
        end
      end
      default: next_state = SG_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= SG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || next_state != state) begin
      phase <= '0;
    end else begin
      phase <= phase + PHASE_W'(1);
    end
  end

  // rising edges counted so the clock stops after one whole word
  always_ff @(posedge mclk) begin
    if (!rst_n || state == SG_IDLE) begin
      pulses <= '0;
    end else if (state == SG_HIGH && next_state != SG_HIGH) begin
      pulses <= pulses + CNT_W'(1);
    end
  end

  // pin driven only while pulses run; released on strobe high or word end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclkOut <= 1'b1;
      sclkOe <= 1'b0;
      wordDone <= 1'b0;
    end else begin
      sclkOut <= (next_state != SG_LOW);
      sclkOe <= (next_state == SG_LOW) || (next_state == SG_HIGH);
      wordDone <= (next_state == SG_DONE);
    end
  end
endmodule // adcsp_sclk_gen
`default_nettype wire

// ===== verification/adcsp_serial_port_properties.sv
// checker of serial clock pin and register commit behaviour
`timescale 1ns/10ps
`default_nettype none
module adcsp_serial_port_properties
  import adcsp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host side, and result load from the core
  input wire logic clockMode,
  input wire logic receive_frame_strobe_n,
  input wire logic transmit_frame_strobe_n,
  input wire logic register_select,
  input wire logic resultLoad,
  // device side
  input wire logic serialClockOut,
  input wire logic serialClockOe,
  input wire logic serialDataOe,
  input wire logic result_ready_n,
  input wire logic controlWrite,
  input wire logic calWrite
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic idle;
  logic [CNT_W-1:0] pulses;
  assign idle = receive_frame_strobe_n & transmit_frame_strobe_n;
  // rising serial clock edges driven in this frame
  always_ff @(posedge mclk) begin
    if (!rst_n || idle) pulses <= '0;
    else if (serialClockOe && $rose(serialClockOut)) pulses <= pulses + CNT_W'(1);
  end
  a_clk_mode: assert property (serialClockOe |-> clockMode)
    else $error("clock driven outside self mode");
  a_clk_start: assert property (clockMode && $fell(idle) |-> ##[3:4] serialClockOe)
    else $error("self clock did not start");
  a_clk_release: assert property (serialClockOe && $rose(idle) |-> ##[1:3] !serialClockOe)
    else $error("self clock not released");
  a_clk_idle_high: assert property (!serialClockOe |-> serialClockOut)
    else $error("released clock not high");
  a_high_width: assert property ($rose(serialClockOut) && serialClockOe |=>
    !serialClockOut || !serialClockOe)
    else $error("clock high too long");
  a_word_end: assert property (pulses == CNT_W'(WORD_BITS) |-> !serialClockOe)
    else $error("clock driven past word end");
  a_idle_quiet: assert property (idle [*5] |-> !serialClockOe && !serialDataOe)
    else $error("pins driven between frames");
  a_ctl_sel: assert property (controlWrite |-> !register_select && !calWrite)
    else $error("control write with select high");
  a_cal_sel: assert property (calWrite |-> register_select)
    else $error("calibration write with select low");
  a_ready_set: assert property (resultLoad |=> !result_ready_n)
    else $error("result ready not flagged");
endmodule // adcsp_serial_port_properties
`default_nettype wire

// ===== verification/adcsp_host_model.sv
// host microcontroller model driving framed serial transfers
`timescale 1ns/10ps
`default_nettype none
module adcsp_host_model (
  // clocks and mode
  input wire logic mclk,
  input wire logic selfMode,
  // resolved wires
  input wire logic sclkWire,
  input wire logic dataWire,
  // host drives
  output logic receive_frame_strobe_n,
  output logic transmit_frame_strobe_n,
  output logic register_select,
  output logic hostClk,
  output logic hostData
);
  initial begin
    receive_frame_strobe_n = 1'b1;
    transmit_frame_strobe_n = 1'b1;
    register_select = 1'b0;
    hostClk = 1'b1;
    hostData = 1'b0;
  end
  // one word, msb first; in external clock mode the clock stalls before bit pauseAt; in either mode the frame ends after bit stopAt
  task automatic xfer(input logic rd, input logic sel, input logic [23:0] wd,
      input int pauseAt, input int stopAt, output logic [23:0] rdat);
    rdat = '0;
    @(posedge mclk) register_select <= sel;
    repeat (3) @(posedge mclk);
    if (rd) receive_frame_strobe_n <= 1'b0;
    else transmit_frame_strobe_n <= 1'b0;
    if (!selfMode) repeat (5) @(posedge mclk);
    for (int i = 23; i >= 0; i--) begin
      if (selfMode) begin
        @(negedge sclkWire) hostData = wd[i];
        @(posedge sclkWire) rdat[i] = dataWire;
      end else begin
        if (i == pauseAt) #300;
        hostClk = 1'b0;
        hostData = wd[i];
        #24 rdat[i] = dataWire;
        hostClk = 1'b1;
        #24;
      end
      if (i == stopAt) break;
    end
    @(posedge mclk) receive_frame_strobe_n <= 1'b1;
    transmit_frame_strobe_n <= 1'b1;
    hostData <= ~hostData;
    // select held while the word commits
    repeat (10) @(posedge mclk);
  endtask
endmodule // adcsp_host_model
`default_nettype wire

// ===== verification/adcsp_serial_port_test.sv
// self-checking bench for the serial port
`timescale 1ns/10ps
`default_nettype none
module adcsp_serial_port_test;
  import adcsp_pkg::*;
  logic mclk, rst_n, clockMode, resultLoad, calReadSelect, hostClk, hostData;
  logic receive_frame_strobe_n, transmit_frame_strobe_n, register_select;
  logic serialClockOut, serialClockOe, serialDataOut, serialDataOe, result_ready_n;
  logic controlWrite, calWrite, resultReadDone, frameBusy;
  wire logic sclkWire, dataWire;
  adcsp_word_t resultData, controlWord, calWord, r;
  int err_count = 0, total_checks = 0, nCtl = 0, nDone = 0, nPulse = 0;
  assign sclkWire = serialClockOe ? serialClockOut : hostClk;
  assign dataWire = serialDataOe ? serialDataOut : hostData;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (controlWrite) nCtl++;
    if (resultReadDone) nDone++;
  end
  always @(posedge sclkWire) nPulse++;
  adcsp_serial_port dut_u (.mclk, .rst_n, .clockMode, .serialClockIn(sclkWire),
    .serialClockOut, .serialClockOe, .serialDataIn(dataWire), .serialDataOut,
    .serialDataOe, .receive_frame_strobe_n, .transmit_frame_strobe_n, .register_select,
    .result_ready_n, .resultData, .resultLoad, .calReadSelect, .controlWord, .calWord,
    .controlWrite, .calWrite, .resultReadDone, .frameBusy);
  adcsp_host_model host_u (.mclk, .selfMode(clockMode), .sclkWire, .dataWire,
    .receive_frame_strobe_n, .transmit_frame_strobe_n, .register_select, .hostClk, .hostData);
  task automatic chk(input adcsp_word_t got, input adcsp_word_t exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic settle();
    @(posedge mclk);
    #1;
  endtask
  task automatic t_reset();
    settle();
    chk(controlWord, 24'h000000);
    chk(calWord, 24'h000000);
    chk(24'(serialClockOe), 24'h000000);
    chk(24'(frameBusy), 24'h000000);
    $display("reset test done");
  endtask
  task automatic t_ext();
    host_u.xfer(1'b0, 1'b0, 24'hA5C3E1, 12, -1, r);
    settle();
    chk(controlWord, 24'hA5C3E1);
    chk(24'(nCtl), 24'h000001);
    host_u.xfer(1'b0, 1'b1, 24'h3C0F96, -1, -1, r);
    settle();
    chk(calWord, 24'h3C0F96);
    chk(controlWord, 24'hA5C3E1);
    host_u.xfer(1'b1, 1'b0, 24'h000000, 5, -1, r);
    chk(r, 24'hA5C3E1);
    $display("external clock test done");
  endtask
  task automatic t_self_read();
    @(posedge mclk) clockMode <= 1'b1;
    resultData <= 24'h5A1E7D;
    resultLoad <= 1'b1;
    @(posedge mclk) resultLoad <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(24'(result_ready_n), 24'h000000);
    nPulse = 0;
    host_u.xfer(1'b1, 1'b1, 24'h000000, -1, -1, r);
    settle();
    chk(r, 24'h5A1E7D);
    chk(24'(nPulse), 24'h000018);
    chk(24'(nDone), 24'h000001);
    chk(24'(result_ready_n), 24'h000001);
    $display("self clock read test done");
  endtask
  task automatic t_self_abort_write();
    host_u.xfer(1'b1, 1'b1, 24'h000000, -1, 20, r);
    settle();
    chk(24'(serialClockOe), 24'h000000);
    chk(24'(nDone), 24'h000001);
    host_u.xfer(1'b0, 1'b0, 24'h0F1E2D, -1, -1, r);
    settle();
    chk(controlWord, 24'h0F1E2D);
    @(posedge mclk) calReadSelect <= 1'b1;
    host_u.xfer(1'b1, 1'b1, 24'h000000, -1, -1, r);
    chk(r, 24'h3C0F96);
    $display("self clock abort and write test done");
  endtask
  initial begin
    rst_n = 1'b0;
    clockMode = 1'b0;
    resultLoad = 1'b0;
    calReadSelect = 1'b0;
    resultData = 24'h000000;
    // three edges so the strobe synchronisers clear
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_ext();
    t_self_read();
    t_self_abort_write();
    give_verdict();
  end
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
endmodule // adcsp_serial_port_test
bind adcsp_serial_port adcsp_serial_port_properties chk_u (.mclk, .rst_n, .clockMode,
  .receive_frame_strobe_n, .transmit_frame_strobe_n, .register_select, .resultLoad,
  .serialClockOut, .serialClockOe, .serialDataOe, .result_ready_n, .controlWrite, .calWrite);
`default_nettype wire
